// ---- design/memory_space_access_unit.v ----
// Purpose: program counter, program address decode and data space access
// Assumes: core drives one request of each kind per cycle at most
// Notes:   data reads answer two edges after the request
`timescale 1ns/100ps
`include "memory_space_consts.vh"

module memory_space_access_unit #(
	parameter [15:0] DATA_BYTES = `DATA_IMPL_BYTES,
	parameter        RAM_AW     = 13
) (
	input  wire        CLOCK,
	input  wire        RST,
	input  wire        PC_LOAD,
	input  wire [23:0] PC_TARGET,
	input  wire        PC_INC,
	input  wire        PC_DEC,
	output reg  [23:0] PC_VALUE,
	input  wire        TBL_REQ,
	input  wire        TBL_WRITE,
	input  wire [7:0]  TABLE_PAGE,
	input  wire [15:0] TBL_OFFSET,
	input  wire [15:0] TBL_WDATA,
	input  wire [23:0] PROG_FETCH_DATA,
	output reg  [23:0] PROG_ADDR,
	output reg         PROG_OK,
	output reg         PROG_UPPER,
	output reg  [15:0] PROG_WORD,
	output reg         PROG_WRITE,
	output reg  [15:0] PROG_WDATA,
	output reg         VEC_RESET,
	output reg         VEC_PRIMARY,
	output reg         VEC_ALTERNATE,
	output reg         VEC_REGION,
	input  wire        RD_REQ,
	input  wire [3:0]  RD_PTR,
	input  wire        RD_BYTE,
	input  wire        RD_POSTMOD,
	input  wire [3:0]  RD_DEST,
	output reg         RD_VALID,
	output reg  [15:0] RD_DATA,
	output reg         PSV_STROBE,
	output reg  [14:0] PSV_ADDR,
	input  wire [15:0] PSV_RDATA,
	input  wire        WR_REQ,
	input  wire [3:0]  WR_PTR,
	input  wire        WR_BYTE,
	input  wire        WR_POSTMOD,
	input  wire [15:0] WR_DATA,
	input  wire        EXT_REQ,
	input  wire        EXT_SIGN,
	input  wire [3:0]  EXT_REG,
	input  wire [3:0]  WREG_SEL,
	output reg  [15:0] WREG_VALUE,
	output reg         ADDR_ERROR_TRAP
);
	// working registers hold the pointers and the load targets
	reg  [15:0] wreg [0:15];
	integer     i;

	// program side
	wire [23:0] table_addr;
	wire [23:0] prog_addr_now;
	wire        dec_allowed;
	wire        dec_upper;
	wire        dec_reset;
	wire        dec_primary;
	wire        dec_alternate;
	wire        dec_region;
	reg  [23:0] next_pc;

	// table operations concatenate page and offset into a full address
	assign table_addr    = {TABLE_PAGE, TBL_OFFSET};
	assign prog_addr_now = TBL_REQ ? table_addr : PC_VALUE;

	prog_decode u_prog_decode (
		.addr          (prog_addr_now),
		.table_op      (TBL_REQ),
		.cfg_enable    (TABLE_PAGE[`CFG_PAGE_BIT]),
		.allowed       (dec_allowed),
		.upper         (dec_upper),
		.reset_vec     (dec_reset),
		.primary_vec   (dec_primary),
		.alternate_vec (dec_alternate),
		.vector_region (dec_region)
	);

	// next program counter: load beats step; bit 0 and bit 23 forced low
	always @* begin
		next_pc = PC_VALUE;
		if (PC_LOAD) begin
			next_pc = PC_TARGET;
		end else if (PC_INC) begin
			next_pc = PC_VALUE + `PC_STEP;
		end else if (PC_DEC) begin
			next_pc = PC_VALUE - `PC_STEP;
		end
		next_pc[0]             = 1'b0;
		next_pc[`CFG_ADDR_BIT] = 1'b0;
	end

	// program counter register, starts at the reset vector
	always @(posedge CLOCK) begin
		if (RST) begin
			PC_VALUE <= `PC_RESET;
		end else begin
			PC_VALUE <= next_pc;
		end
	end

	// registered program address and its classification
	always @(posedge CLOCK) begin
		if (RST) begin
			PROG_ADDR     <= `PC_RESET;
			PROG_OK       <= 1'b0;
			PROG_UPPER    <= 1'b0;
			VEC_RESET     <= 1'b0;
			VEC_PRIMARY   <= 1'b0;
			VEC_ALTERNATE <= 1'b0;
			VEC_REGION    <= 1'b0;
			PROG_WRITE    <= 1'b0;
			PROG_WDATA    <= `ZERO_WORD;
		end else begin
			PROG_ADDR     <= prog_addr_now;
			PROG_OK       <= dec_allowed;
			PROG_UPPER    <= dec_upper;
			VEC_RESET     <= dec_reset;
			VEC_PRIMARY   <= dec_primary;
			VEC_ALTERNATE <= dec_alternate;
			VEC_REGION    <= dec_region;
			// a denied table write never reaches the array
			PROG_WRITE    <= TBL_REQ & TBL_WRITE & dec_allowed;
			PROG_WDATA    <= TBL_WDATA;
		end
	end

	// word view of the fetched location; the phantom byte reads zero
	always @(posedge CLOCK) begin
		if (RST) begin
			PROG_WORD <= `ZERO_WORD;
		end else if (!PROG_OK) begin
			PROG_WORD <= `ZERO_WORD;
		end else if (PROG_UPPER) begin
			PROG_WORD <= {`UPPER_PAD, PROG_FETCH_DATA[23:16]};
		end else begin
			PROG_WORD <= PROG_FETCH_DATA[15:0];
		end
	end

	// data side: read and write address units work independently
	wire [15:0] rd_ea;
	wire [15:0] wr_ea;
	wire [15:0] rd_step;
	wire [15:0] wr_step;
	wire        rd_mis;
	wire        wr_mis;
	wire        rd_psv;
	wire        rd_impl;
	wire        wr_impl;
	wire        ram_wen;
	wire [1:0]  ram_lanes;
	wire [15:0] ram_wdata;
	wire [15:0] ram_q;

	// post-modify amount follows the operand size
	function [15:0] step_size;
		input byte_op;
		step_size = byte_op ? `BYTE_STEP : `WORD_STEP;
	endfunction

	// only the lower half below the implemented size hits the array
	function ram_hit;
		input [15:0] ea;
		ram_hit = ~ea[`PSV_BIT] & (ea < DATA_BYTES);
	endfunction

	// a word at an odd byte address cannot be fetched in one access
	function word_misaligned;
		input        byte_op;
		input [15:0] ea;
		word_misaligned = ~byte_op & ea[0];
	endfunction

	assign rd_ea   = wreg[RD_PTR];
	assign wr_ea   = wreg[WR_PTR];
	assign rd_step = step_size(RD_BYTE);
	assign wr_step = step_size(WR_BYTE);

	// word access at an odd byte address is an alignment fault
	assign rd_mis  = RD_REQ & word_misaligned(RD_BYTE, rd_ea);
	assign wr_mis  = WR_REQ & word_misaligned(WR_BYTE, wr_ea);

	// upper half goes to the visibility window, lower half below the implemented size to memory
	assign rd_psv  = rd_ea[`PSV_BIT];
	assign rd_impl = ram_hit(rd_ea);
	assign wr_impl = ram_hit(wr_ea);

	// byte writes strobe only the addressed lane; data copied to both
	assign ram_lanes = WR_BYTE ? (wr_ea[0] ? 2'b10 : 2'b01) : 2'b11;
	assign ram_wdata = WR_BYTE ? {WR_DATA[7:0], WR_DATA[7:0]} : WR_DATA;
	// misaligned word writes are dropped; writes to the window are ignored
	assign ram_wen   = WR_REQ & wr_impl & ~wr_mis;

	data_ram #(
		.AW (RAM_AW)
	) u_data_ram (
		.clk   (CLOCK),
		.raddr (rd_ea[RAM_AW:1]),
		.rdata (ram_q),
		.wen   (ram_wen),
		.lanes (ram_lanes),
		.waddr (wr_ea[RAM_AW:1]),
		.wdata (ram_wdata)
	);

	// first read stage: remember what the answer must look like
	reg        rd_pend;
	reg        rd_byte_q;
	reg        rd_lane_q;
	reg [1:0]  rd_src_q;
	reg [3:0]  rd_dest_q;
	reg        rd_mis_q;

	always @(posedge CLOCK) begin
		if (RST) begin
			rd_pend    <= 1'b0;
			rd_byte_q  <= 1'b0;
			rd_lane_q  <= 1'b0;
			rd_src_q   <= `SRC_RAM;
			rd_dest_q  <= 4'h0;
			rd_mis_q   <= 1'b0;
			PSV_STROBE <= 1'b0;
			PSV_ADDR   <= 15'h0000;
		end else begin
			rd_pend    <= RD_REQ;
			rd_byte_q  <= RD_BYTE;
			rd_lane_q  <= rd_ea[0];
			rd_dest_q  <= RD_DEST;
			rd_mis_q   <= rd_mis;
			if (rd_psv) begin
				rd_src_q <= `SRC_PSV;
			end else if (rd_impl) begin
				rd_src_q <= `SRC_RAM;
			end else begin
				rd_src_q <= `SRC_ZERO;
			end
			PSV_STROBE <= RD_REQ & rd_psv;
			PSV_ADDR   <= rd_ea[14:0];
		end
	end

	// answer formation: whole word first, then lane select for bytes
	reg [15:0] rd_word;
	reg [15:0] rd_value;

	always @* begin
		rd_word = `ZERO_WORD;
		if (rd_src_q == `SRC_RAM) begin
			rd_word = ram_q;
		end else if (rd_src_q == `SRC_PSV) begin
			rd_word = PSV_RDATA;
		end
		if (rd_byte_q) begin
			// selected byte always lands on the low byte of the path
			rd_value = {`ZERO_BYTE, rd_lane_q ? rd_word[15:8] : rd_word[7:0]};
		end else begin
			rd_value = rd_word;
		end
	end

	// read answer and trap; a faulting read still delivers its data
	always @(posedge CLOCK) begin
		if (RST) begin
			RD_VALID        <= 1'b0;
			RD_DATA         <= `ZERO_WORD;
			ADDR_ERROR_TRAP <= 1'b0;
		end else begin
			RD_VALID        <= rd_pend;
			if (rd_pend) begin
				RD_DATA <= rd_value;
			end
			// write fault traps at once, read fault together with its answer
			ADDR_ERROR_TRAP <= (rd_pend & rd_mis_q) | wr_mis;
		end
	end

	// working register updates; later statements take priority
	wire [15:0] ext_src;
	wire [15:0] ext_value;

	assign ext_src   = wreg[EXT_REG];
	assign ext_value = EXT_SIGN ? {{8{ext_src[7]}}, ext_src[7:0]}
	                            : {`ZERO_BYTE, ext_src[7:0]};

	always @(posedge CLOCK) begin
		if (RST) begin
			for (i = 0; i < 16; i = i + 1) begin
				wreg[i] <= `WREG_RESET;
			end
		end else begin
			// pointer steps after use; wraps inside the 64K byte space
			if (RD_REQ & RD_POSTMOD) begin
				wreg[RD_PTR] <= rd_ea + rd_step;
			end
			if (WR_REQ & WR_POSTMOD) begin
				wreg[WR_PTR] <= wr_ea + wr_step;
			end
			if (EXT_REQ) begin
				wreg[EXT_REG] <= ext_value;
			end
			// load result wins so a completed read is never lost
			if (rd_pend) begin
				if (rd_byte_q) begin
					wreg[rd_dest_q][7:0] <= rd_value[7:0];
				end else begin
					wreg[rd_dest_q] <= rd_value;
				end
			end
		end
	end

	// register observation port for the core
	always @(posedge CLOCK) begin
		if (RST) begin
			WREG_VALUE <= `WREG_RESET;
		end else begin
			WREG_VALUE <= wreg[WREG_SEL];
		end
	end
endmodule

// ---- shared/memory_space_consts.vh ----
// Purpose: shared constants for the memory space access unit
// Assumes: included by bare name from design files
// Notes:   addresses are byte addresses unless stated otherwise
`ifndef MEMORY_SPACE_CONSTS_VH
`define MEMORY_SPACE_CONSTS_VH

// program space
`define PROG_AW         24
`define PC_RESET        24'h00_0000
`define PC_STEP         24'h00_0002
`define USER_TOP        24'h7F_FFFF
`define RESET_VEC_END   24'h00_0003
`define PRI_VEC_LO      24'h00_0004
`define PRI_VEC_HI      24'h00_00FF
`define ALT_VEC_LO      24'h00_0100
`define ALT_VEC_HI      24'h00_01FF
`define VEC_REGION_END  24'h00_0200
`define CFG_PAGE_BIT    7
`define CFG_ADDR_BIT    23
`define UPPER_PAD       8'h00

// data space
`define DATA_AW         16
`define PSV_BIT         15
`define DATA_IMPL_BYTES 16'h4000
`define BYTE_STEP       16'h0001
`define WORD_STEP       16'h0002
`define ZERO_WORD       16'h0000
`define ZERO_BYTE       8'h00
`define WREG_RESET      16'h0000

// read source codes
`define SRC_RAM         2'h0
`define SRC_PSV         2'h1
`define SRC_ZERO        2'h2

`endif

// ---- design/prog_decode.v ----
// Purpose: classify a program space byte address
// Assumes: purely combinational, address already formed
// Notes:   config space needs a table operation with the page flag set
`timescale 1ns/100ps
`include "memory_space_consts.vh"

module prog_decode (
	input  wire [23:0] addr,
	input  wire        table_op,
	input  wire        cfg_enable,
	output wire        allowed,
	output wire        upper,
	output wire        reset_vec,
	output wire        primary_vec,
	output wire        alternate_vec,
	output wire        vector_region
);
	// user half always open, upper half only through table page flag
	assign allowed       = (addr <= `USER_TOP) | (table_op & cfg_enable);
	assign upper         = addr[0];
	assign reset_vec     = (addr <= `RESET_VEC_END);
	assign primary_vec   = (addr >= `PRI_VEC_LO) & (addr <= `PRI_VEC_HI);
	assign alternate_vec = (addr >= `ALT_VEC_LO) & (addr <= `ALT_VEC_HI);
	assign vector_region = (addr < `VEC_REGION_END);
endmodule

// ---- design/data_ram.v ----
// Purpose: word-wide data memory with two byte write lanes
// Assumes: one read port and one write port, both synchronous
// Notes:   read-during-write to the same word returns the old word
`timescale 1ns/100ps
`include "memory_space_consts.vh"

module data_ram #(
	parameter AW = 13
) (
	input  wire          clk,
	input  wire [AW-1:0] raddr,
	output reg  [15:0]   rdata,
	input  wire          wen,
	input  wire [1:0]    lanes,
	input  wire [AW-1:0] waddr,
	input  wire [15:0]   wdata
);
	reg [15:0] mem [0:(1<<AW)-1];

	// shared word decode, separate lane strobes
	always @(posedge clk) begin
		rdata <= mem[raddr];
		if (wen & lanes[0]) begin
			mem[waddr][7:0] <= wdata[7:0];
		end
		if (wen & lanes[1]) begin
			mem[waddr][15:8] <= wdata[15:8];
		end
	end
endmodule

// ---- verification/mem_access_checker_assertions.sv ----
// Purpose: checks program counter, program decode and read timing
// Assumes: bound to memory_space_access_unit, a single clock domain
// Notes:   watches only top-level ports
`timescale 1ns/100ps

module mem_access_checker (
	input wire        CLOCK,
	input wire        RST,
	input wire        PC_LOAD,
	input wire [23:0] PC_TARGET,
	input wire        PC_INC,
	input wire [23:0] PC_VALUE,
	input wire        TBL_REQ,
	input wire [7:0]  TABLE_PAGE,
	input wire [15:0] TBL_OFFSET,
	input wire [23:0] PROG_FETCH_DATA,
	input wire [23:0] PROG_ADDR,
	input wire        PROG_OK,
	input wire        PROG_UPPER,
	input wire [15:0] PROG_WORD,
	input wire        VEC_RESET,
	input wire        VEC_PRIMARY,
	input wire        VEC_ALTERNATE,
	input wire        VEC_REGION,
	input wire        RD_REQ,
	input wire        RD_VALID,
	input wire        PSV_STROBE
);
	reg [23:0] last_fetch;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	// fetch data of the previous cycle, so bit slices avoid $past
	always @(posedge CLOCK) begin
		last_fetch <= PROG_FETCH_DATA;
	end

	property p_pc_even; PC_VALUE[0] == 1'b0 && PC_VALUE[23] == 1'b0; endproperty
	a_pc_even: assert property (p_pc_even) else $error("pc odd or above 23 bits");

	property p_pc_load; PC_LOAD |=> PC_VALUE == ($past(PC_TARGET) & 24'h7F_FFFE); endproperty
	a_pc_load: assert property (p_pc_load) else $error("pc load wrong");

	property p_pc_inc; PC_INC && !PC_LOAD |=> PC_VALUE == $past(PC_VALUE) + 24'h00_0002; endproperty
	a_pc_inc: assert property (p_pc_inc) else $error("pc step wrong");

	property p_addr;
		1'b1 |=> PROG_ADDR == ($past(TBL_REQ) ? {$past(TABLE_PAGE), $past(TBL_OFFSET)}
			: $past(PC_VALUE));
	endproperty
	a_addr: assert property (p_addr) else $error("program address source wrong");

	// upper half only reachable by a table access with the page flag
	property p_ok; !$past(RST) |-> PROG_OK == (!PROG_ADDR[23] || $past(TBL_REQ)); endproperty
	a_ok: assert property (p_ok) else $error("program access permission wrong");

	property p_word;
		!$past(RST) |-> PROG_WORD == (!$past(PROG_OK) ? 16'h0000 : $past(PROG_UPPER)
			? {8'h00, last_fetch[23:16]} : last_fetch[15:0]);
	endproperty
	a_word: assert property (p_word) else $error("program word lane wrong");

	property p_vec;
		!$past(RST) |-> VEC_RESET == (PROG_ADDR <= 24'h00_0003)
			&& VEC_PRIMARY == (PROG_ADDR >= 24'h00_0004 && PROG_ADDR <= 24'h00_00FF);
	endproperty
	a_vec: assert property (p_vec) else $error("reset or primary vector decode wrong");

	property p_alt;
		!$past(RST) |-> VEC_ALTERNATE == (PROG_ADDR[23:8] == 16'h0001)
			&& VEC_REGION == (PROG_ADDR < 24'h00_0200);
	endproperty
	a_alt: assert property (p_alt) else $error("alternate vector decode wrong");

	property p_rd; RD_REQ |-> ##2 RD_VALID; endproperty
	a_rd: assert property (p_rd) else $error("read answer late or missing");

	property p_psv; PSV_STROBE |-> $past(RD_REQ); endproperty
	a_psv: assert property (p_psv) else $error("window strobe without read");
endmodule

// ---- verification/prog_space_model.sv ----
// Purpose: program memory and visibility window seen by the unit
// Assumes: answers combinationally from the address outputs
// Notes:   window data is inverted when not strobed, so stale reads show
`timescale 1ns/100ps

module prog_space_model (
	input  wire [23:0] prog_addr,
	input  wire        psv_strobe,
	input  wire [14:0] psv_addr,
	output wire [23:0] prog_fetch_data,
	output wire [15:0] psv_rdata
);
	// jump at zero with its target word beside it, a pattern elsewhere
	assign prog_fetch_data = (prog_addr[23:1] == 23'h0) ? 24'h04_0000
		: (prog_addr[23:1] == 23'h1) ? 24'h00_0200
		: {prog_addr[7:0] ^ 8'hC3, prog_addr[15:0] ^ 16'h5AA5};
	assign psv_rdata = psv_strobe ? {1'b0, psv_addr} ^ 16'h6C6C : ~({1'b0, psv_addr} ^ 16'h6C6C);
endmodule

// ---- verification/memory_space_access_unit_test.sv ----
// Purpose: directed test of memory_space_access_unit
// Assumes: prog_space_model answers program and window fetches
// Notes:   working registers are seeded through data memory loads
`timescale 1ns/100ps

module memory_space_access_unit_test;
	reg         CLOCK = 1'b0;
	reg         RST = 1'b1;
	reg         PC_LOAD, PC_INC, PC_DEC, TBL_REQ, TBL_WRITE, RD_REQ, RD_BYTE, RD_POSTMOD;
	reg         WR_REQ, WR_BYTE, WR_POSTMOD, EXT_REQ, EXT_SIGN;
	reg  [23:0] PC_TARGET;
	reg  [7:0]  TABLE_PAGE;
	reg  [15:0] TBL_OFFSET, TBL_WDATA, WR_DATA;
	reg  [3:0]  RD_PTR, RD_DEST, WR_PTR, EXT_REG, WREG_SEL;
	wire [23:0] PC_VALUE, PROG_ADDR, PROG_FETCH_DATA;
	wire [15:0] PROG_WORD, PROG_WDATA, RD_DATA, PSV_RDATA, WREG_VALUE;
	wire [14:0] PSV_ADDR;
	wire        PROG_OK, PROG_UPPER, PROG_WRITE, VEC_RESET, VEC_PRIMARY, VEC_ALTERNATE;
	wire        VEC_REGION, RD_VALID, PSV_STROBE, ADDR_ERROR_TRAP;
	integer     num_errors = 0;
	integer     tests_run = 0;
	reg         trap;
	reg  [15:0] psv;

	memory_space_access_unit u_dut (
		.CLOCK           (CLOCK),
		.RST             (RST),
		.PC_LOAD         (PC_LOAD),
		.PC_TARGET       (PC_TARGET),
		.PC_INC          (PC_INC),
		.PC_DEC          (PC_DEC),
		.PC_VALUE        (PC_VALUE),
		.TBL_REQ         (TBL_REQ),
		.TBL_WRITE       (TBL_WRITE),
		.TABLE_PAGE      (TABLE_PAGE),
		.TBL_OFFSET      (TBL_OFFSET),
		.TBL_WDATA       (TBL_WDATA),
		.PROG_FETCH_DATA (PROG_FETCH_DATA),
		.PROG_ADDR       (PROG_ADDR),
		.PROG_OK         (PROG_OK),
		.PROG_UPPER      (PROG_UPPER),
		.PROG_WORD       (PROG_WORD),
		.PROG_WRITE      (PROG_WRITE),
		.PROG_WDATA      (PROG_WDATA),
		.VEC_RESET       (VEC_RESET),
		.VEC_PRIMARY     (VEC_PRIMARY),
		.VEC_ALTERNATE   (VEC_ALTERNATE),
		.VEC_REGION      (VEC_REGION),
		.RD_REQ          (RD_REQ),
		.RD_PTR          (RD_PTR),
		.RD_BYTE         (RD_BYTE),
		.RD_POSTMOD      (RD_POSTMOD),
		.RD_DEST         (RD_DEST),
		.RD_VALID        (RD_VALID),
		.RD_DATA         (RD_DATA),
		.PSV_STROBE      (PSV_STROBE),
		.PSV_ADDR        (PSV_ADDR),
		.PSV_RDATA       (PSV_RDATA),
		.WR_REQ          (WR_REQ),
		.WR_PTR          (WR_PTR),
		.WR_BYTE         (WR_BYTE),
		.WR_POSTMOD      (WR_POSTMOD),
		.WR_DATA         (WR_DATA),
		.EXT_REQ         (EXT_REQ),
		.EXT_SIGN        (EXT_SIGN),
		.EXT_REG         (EXT_REG),
		.WREG_SEL        (WREG_SEL),
		.WREG_VALUE      (WREG_VALUE),
		.ADDR_ERROR_TRAP (ADDR_ERROR_TRAP)
	);
	prog_space_model u_model (.prog_addr(PROG_ADDR), .psv_strobe(PSV_STROBE),
		.psv_addr(PSV_ADDR), .prog_fetch_data(PROG_FETCH_DATA), .psv_rdata(PSV_RDATA));

	// 25 MHz
	always #20 CLOCK = ~CLOCK;

	task chk(input [23:0] seen, input [23:0] exp);
	begin
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task print_verdict;
	begin
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	// same pattern the program memory model holds
	function [23:0] exp_fetch(input [23:0] a);
		exp_fetch = (a[23:1] == 23'h0) ? 24'h04_0000 : (a[23:1] == 23'h1) ? 24'h00_0200
			: {a[7:0] ^ 8'hC3, a[15:0] ^ 16'h5AA5};
	endfunction

	task wr(input [3:0] p, input b, input m, input [15:0] d);
	begin
		@(posedge CLOCK);
		{WR_REQ, WR_PTR, WR_BYTE, WR_POSTMOD, WR_DATA} <= {1'b1, p, b, m, d};
		@(posedge CLOCK);
		WR_REQ <= 1'b0;
		#1 trap = ADDR_ERROR_TRAP;
	end
	endtask

	// answer lands one edge after the taking edge
	task rd(input [3:0] p, input b, input m, input [3:0] dst, input [15:0] e, input t);
	begin
		@(posedge CLOCK);
		{RD_REQ, RD_PTR, RD_BYTE, RD_POSTMOD, RD_DEST} <= {1'b1, p, b, m, dst};
		@(posedge CLOCK);
		RD_REQ <= 1'b0;
		#1 psv = {PSV_STROBE, PSV_ADDR};
		@(posedge CLOCK);
		#1 chk({RD_VALID, ADDR_ERROR_TRAP, RD_DATA}, {1'b1, t, e});
	end
	endtask

	task wq(input [3:0] s, input [15:0] e);
	begin
		@(posedge CLOCK);
		WREG_SEL <= s;
		@(posedge CLOCK);
		#1 chk(WREG_VALUE, e);
	end
	endtask

	task ext(input [3:0] r, input s);
	begin
		@(posedge CLOCK);
		{EXT_REQ, EXT_SIGN, EXT_REG} <= {1'b1, s, r};
		@(posedge CLOCK);
		EXT_REQ <= 1'b0;
	end
	endtask

	// load clears forbidden bits; increment beats decrement
	task t_pc;
	begin
		#1 chk(PC_VALUE, 24'h00_0000);
		@(posedge CLOCK);
		{PC_LOAD, PC_TARGET} <= {1'b1, 24'h80_0101};
		@(posedge CLOCK);
		{PC_LOAD, PC_INC, PC_DEC} <= 3'b011;
		#1 chk(PC_VALUE, 24'h00_0100);
		@(posedge CLOCK);
		PC_INC <= 1'b0;
		#1 chk(PC_VALUE, 24'h00_0102);
		@(posedge CLOCK);
		PC_DEC <= 1'b0;
		#1 chk(PC_VALUE, 24'h00_0100);
	end
	endtask

	task tp(input [23:0] a, input w);
		reg [23:0] f;
	begin
		f = exp_fetch(a);
		@(posedge CLOCK);
		{TBL_REQ, TBL_WRITE, TABLE_PAGE, TBL_OFFSET, TBL_WDATA} <= {1'b1, w, a, ~a[15:0]};
		@(posedge CLOCK);
		TBL_REQ <= 1'b0;
		#1 chk(PROG_ADDR, a);
		chk({PROG_OK, PROG_UPPER, PROG_WRITE, PROG_WDATA}, {1'b1, a[0], w, ~a[15:0]});
		chk({VEC_RESET, VEC_PRIMARY, VEC_ALTERNATE, VEC_REGION}, {a <= 24'h00_0003,
			a >= 24'h00_0004 && a <= 24'h00_00FF, a[23:8] == 16'h0001, a < 24'h00_0200});
		@(posedge CLOCK);
		#1 chk(PROG_WORD, a[0] ? {8'h00, f[23:16]} : f[15:0]);
	end
	endtask

	// vector edges, first user word, configuration half via page flag
	task t_prog;
	begin
		tp(24'h00_0003, 1'b0);
		tp(24'h00_0004, 1'b1);
		tp(24'h00_00FF, 1'b0);
		tp(24'h00_0100, 1'b1);
		tp(24'h00_01FF, 1'b0);
		tp(24'h00_0200, 1'b1);
		tp(24'hFF_0001, 1'b1);
	end
	endtask

	task t_word;
	begin
		wr(4'h0, 1'b0, 1'b0, 16'h4002);
		rd(4'h0, 1'b0, 1'b0, 4'h5, 16'h4002, 1'b0);
		wq(4'h5, 16'h4002);
		rd(4'h5, 1'b0, 1'b0, 4'h1, 16'h0000, 1'b0);
	end
	endtask

	task t_byte;
	begin
		wr(4'h0, 1'b0, 1'b0, 16'h1281);
		rd(4'h0, 1'b0, 1'b0, 4'h1, 16'h1281, 1'b0);
		wr(4'h6, 1'b1, 1'b1, 16'hAA7E);
		wq(4'h6, 16'h0001);
		wr(4'h6, 1'b1, 1'b0, 16'h553C);
		chk(trap, 1'b0);
		rd(4'h0, 1'b0, 1'b0, 4'h3, 16'h3C7E, 1'b0);
		rd(4'h6, 1'b1, 1'b0, 4'h1, 16'h003C, 1'b0);
		wq(4'h1, 16'h123C);
	end
	endtask

	task t_fault;
	begin
		wr(4'h6, 1'b0, 1'b0, 16'hFFFF);
		chk(trap, 1'b1);
		rd(4'h0, 1'b0, 1'b0, 4'h3, 16'h3C7E, 1'b0);
		rd(4'h6, 1'b0, 1'b1, 4'h7, 16'h3C7E, 1'b1);
		wq(4'h6, 16'h0003);
		wq(4'h7, 16'h3C7E);
	end
	endtask

	// a sign-extended pointer lands in the window half
	task t_ext;
	begin
		wr(4'h0, 1'b0, 1'b0, 16'hAB80);
		rd(4'h0, 1'b0, 1'b0, 4'h4, 16'hAB80, 1'b0);
		ext(4'h4, 1'b1);
		wq(4'h4, 16'hFF80);
		rd(4'h4, 1'b0, 1'b0, 4'h2, 16'h13EC, 1'b0);
		chk(psv, 16'hFF80);
		ext(4'h1, 1'b0);
		wq(4'h1, 16'h003C);
	end
	endtask

	initial begin
		{PC_LOAD, PC_INC, PC_DEC, TBL_REQ, TBL_WRITE, RD_REQ, RD_BYTE, RD_POSTMOD, WR_REQ,
			WR_BYTE, WR_POSTMOD, EXT_REQ, EXT_SIGN, PC_TARGET, TABLE_PAGE, TBL_OFFSET,
			TBL_WDATA, WR_DATA, RD_PTR, RD_DEST, WR_PTR, EXT_REG, WREG_SEL} = 0;
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		t_pc;
		t_prog;
		t_word;
		t_byte;
		t_fault;
		t_ext;
		print_verdict;
	end

	// the whole run needs under a hundred cycles
	initial begin
		repeat (3000) @(posedge CLOCK);
		num_errors = num_errors + 1;
		print_verdict;
	end
endmodule

bind memory_space_access_unit mem_access_checker u_chk (
	.CLOCK           (CLOCK),
	.RST             (RST),
	.PC_LOAD         (PC_LOAD),
	.PC_TARGET       (PC_TARGET),
	.PC_INC          (PC_INC),
	.PC_VALUE        (PC_VALUE),
	.TBL_REQ         (TBL_REQ),
	.TABLE_PAGE      (TABLE_PAGE),
	.TBL_OFFSET      (TBL_OFFSET),
	.PROG_FETCH_DATA (PROG_FETCH_DATA),
	.PROG_ADDR       (PROG_ADDR),
	.PROG_OK         (PROG_OK),
	.PROG_UPPER      (PROG_UPPER),
	.PROG_WORD       (PROG_WORD),
	.VEC_RESET       (VEC_RESET),
	.VEC_PRIMARY     (VEC_PRIMARY),
	.VEC_ALTERNATE   (VEC_ALTERNATE),
	.VEC_REGION      (VEC_REGION),
	.RD_REQ          (RD_REQ),
	.RD_VALID        (RD_VALID),
	.PSV_STROBE      (PSV_STROBE)
);
